// ### rtl/pcoc_converter.sv
`timescale 1ns/1ps
`include "pcoc_params.svh"
module pcoc_converter
   import pcoc_pkg::*;
#(
   parameter int CNT_W = 18,
   parameter int VAL_W = 16
) (
   input wire logic clock, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic pulseIn, // Conditioned pulse input
   input wire logic [7:0] counterMode, // Counter mode code
   input wire logic fallingEdge, // Count on falling edge
   input wire logic triggerFirst, // Trigger on first pulse of group
   input wire logic [CNT_W-1:0] pulsesToCount, // Pulses per group
   input wire logic [15:0] windowMs, // Measuring window length
   output logic [CNT_W-1:0] countValue, // Pulse count or elapsed ms
   output logic triggerOut, // Trigger mode level
   input wire logic [3:0] outputType, // Output type code
   input wire logic signed [VAL_W-1:0] controlValue, // Control input value
   input wire logic signed [VAL_W-1:0] controlMin, // Control span minimum
   input wire logic signed [VAL_W-1:0] controlMax, // Control span maximum
   input wire logic signed [VAL_W-1:0] outMin, // Output range minimum
   input wire logic signed [VAL_W-1:0] outMax, // Output range maximum
   input wire logic enableUsed, // Enable input selected
   input wire logic signed [VAL_W-1:0] enableValue, // Enable source value
   input wire logic signed [VAL_W-1:0] enableSrcMin, // Enable source minimum
   input wire logic signed [VAL_W-1:0] enableSrcMax, // Enable source maximum
   input wire logic [2:0] enableResponse, // Enable response code
   input wire logic overrideUsed, // Override input selected
   input wire logic signed [VAL_W-1:0] overrideValue, // Override source value
   input wire logic signed [VAL_W-1:0] overrideSrcMin, // Override source minimum
   input wire logic signed [VAL_W-1:0] overrideSrcMax, // Override source maximum
   input wire logic overrideResponse, // Override response code
   input wire logic signed [VAL_W-1:0] outputAtOverride, // Value while overridden
   input wire logic [15:0] delayMs, // Delay before evaluation
   input wire logic [15:0] rampUpMs, // Ramp up time, zero is none
   input wire logic [15:0] rampDownMs, // Ramp down time, zero is none
   input wire logic [15:0] blinkMs, // Blink half period, ms per phase
   output logic signed [VAL_W-1:0] outValue, // Output value in output units
   output logic outDigital // Digital output level
);

   //------------------------------------------------------------
   // Millisecond tick
   //------------------------------------------------------------
   localparam int MS_CYC = `PCOC_CYC_PER_MS;
   logic [15:0] tickCount;
   logic msTick;

   // Free-running tick every millisecond
   always_ff @(posedge clock) begin
      if (reset || msTick) begin
         tickCount <= 16'h0000;
      end else begin
         tickCount <= tickCount + 16'h0001;
      end
   end
   assign msTick = (tickCount == 16'(MS_CYC - 1));

   //------------------------------------------------------------
   // Pulse counter
   //------------------------------------------------------------
   logic pulseLast;
   logic pulseEdge;
   logic [CNT_W-1:0] pulseCount;
   logic [15:0] msCount;
   logic groupDone;
   logic firstOfGroup;

   // Edge detect on selected polarity
   always_ff @(posedge clock) begin
      if (reset) begin
         pulseLast <= 1'b0;
      end else begin
         pulseLast <= pulseIn;
      end
   end
   assign pulseEdge = fallingEdge ? (pulseLast && !pulseIn) : (!pulseLast && pulseIn);
   assign groupDone = pulseEdge && (pulseCount + CNT_W'(1) >= pulsesToCount);
   assign firstOfGroup = pulseEdge && (pulseCount == '0);

   // Count pulses and milliseconds per mode
   always_ff @(posedge clock) begin
      if (reset) begin
         pulseCount <= '0;
         msCount <= 16'h0000;
         countValue <= '0;
      end else begin
         case (counterMode)
            `PCOC_MODE_WINDOW: begin
               if (msTick && (msCount + 16'h0001 >= windowMs)) begin
                  countValue <= pulseCount + (pulseEdge ? CNT_W'(1) : CNT_W'(0));
                  pulseCount <= '0;
                  msCount <= 16'h0000;
               end else begin
                  if (pulseEdge) begin
                     pulseCount <= pulseCount + CNT_W'(1);
                  end
                  if (msTick) begin
                     msCount <= msCount + 16'h0001;
                  end
               end
            end
            `PCOC_MODE_TIMED: begin
               if (groupDone) begin
                  countValue <= CNT_W'(msCount);
                  pulseCount <= '0;
                  msCount <= 16'h0000;
               end else begin
                  if (pulseEdge) begin
                     pulseCount <= pulseCount + CNT_W'(1);
                  end
                  if (msTick && msCount < `PCOC_TIME_MAX_MS) begin
                     msCount <= msCount + 16'h0001;
                  end
                  if (msCount == `PCOC_TIME_MAX_MS) begin
                     countValue <= CNT_W'(msCount);
                  end
               end
            end
            `PCOC_MODE_TRIG: begin
               if (groupDone) begin
                  pulseCount <= '0;
               end else if (pulseEdge) begin
                  pulseCount <= pulseCount + CNT_W'(1);
               end
               countValue <= pulseCount;
            end
            default: begin
               pulseCount <= '0;
               msCount <= 16'h0000;
            end
         endcase
      end
   end

   // Trigger level: ON at group point, OFF on next counted pulse
   always_ff @(posedge clock) begin
      if (reset || counterMode != `PCOC_MODE_TRIG) begin
         triggerOut <= 1'b0;
      end else if (pulseEdge) begin
         triggerOut <= triggerFirst ? firstOfGroup : groupDone;
      end
   end

   //------------------------------------------------------------
   // Digital interpretation with hysteresis
   //------------------------------------------------------------
   logic enableLevel;
   logic overrideLevel;
   logic controlLevel;

   // OFF at or below minimum, ON at or above maximum, else hold
   always_ff @(posedge clock) begin
      if (reset) begin
         enableLevel <= 1'b0;
         overrideLevel <= 1'b0;
         controlLevel <= 1'b0;
      end else begin
         if (enableValue <= enableSrcMin) enableLevel <= 1'b0;
         else if (enableValue >= enableSrcMax) enableLevel <= 1'b1;
         if (overrideValue <= overrideSrcMin) overrideLevel <= 1'b0;
         else if (overrideValue >= overrideSrcMax) overrideLevel <= 1'b1;
         if (controlValue <= controlMin) controlLevel <= 1'b0;
         else if (controlValue >= controlMax) controlLevel <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // Linear scaling and clamping
   //------------------------------------------------------------
   logic signed [VAL_W:0] ctlSpan;
   logic signed [VAL_W:0] outSpan;
   logic signed [VAL_W:0] ctlOff;
   logic signed [2*VAL_W+1:0] scaled;
   logic signed [VAL_W-1:0] linTarget;
   logic signed [VAL_W-1:0] loLim;
   logic signed [VAL_W-1:0] hiLim;

   // y = m*x + a written as outMin + span*(x-xmin)/(xmax-xmin)
   always_comb begin
      ctlSpan = (VAL_W+1)'(controlMax) - (VAL_W+1)'(controlMin);
      outSpan = (VAL_W+1)'(outMax) - (VAL_W+1)'(outMin);
      ctlOff = (VAL_W+1)'(controlValue) - (VAL_W+1)'(controlMin);
      if (ctlSpan <= 0) begin
         scaled = '0;
      end else begin
         scaled = (outSpan * ctlOff) / ctlSpan;
      end
      loLim = (outMin < outMax) ? outMin : outMax;
      hiLim = (outMin < outMax) ? outMax : outMin;
      if (scaled + outMin < loLim) linTarget = loLim;
      else if (scaled + outMin > hiLim) linTarget = hiLim;
      else linTarget = VAL_W'(scaled + outMin);
   end

   //------------------------------------------------------------
   // Source arbitration
   //------------------------------------------------------------
   logic overrideActive;
   logic enableActive;
   pcoc_dis_e disAction;
   logic isDigital;
   logic signed [VAL_W-1:0] target;

   // Override first, then enable, then control
   always_comb begin
      overrideActive = overrideUsed &&
         ((overrideResponse == `PCOC_OVR_WHEN_ON) ? overrideLevel : !overrideLevel);
      enableActive = !enableUsed ||
         ((enableResponse <= `PCOC_EN_ON_GROUP_MAX) ? enableLevel : !enableLevel);
      case (enableResponse)
         3'h0, 3'h3: disAction = PCOC_DIS_SHUT;
         3'h1, 3'h4: disAction = PCOC_DIS_RAMP;
         default: disAction = PCOC_DIS_KEEP;
      endcase
      isDigital = (outputType >= `PCOC_OT_DIG_NORM);
      if (overrideActive) target = outputAtOverride;
      else if (!enableActive) target = (disAction == PCOC_DIS_KEEP) ? outValue : loLim;
      else target = linTarget;
   end

   //------------------------------------------------------------
   // Delay before evaluation
   //------------------------------------------------------------
   pcoc_state_e state;
   logic [15:0] delayCount;

   // Hold output at reset value until the delay elapses
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= PCOC_ST_DELAY;
         delayCount <= 16'h0000;
      end else begin
         case (state)
            PCOC_ST_DELAY: begin
               if (delayCount >= delayMs) state <= PCOC_ST_RUN;
               else if (msTick) delayCount <= delayCount + 16'h0001;
            end
            PCOC_ST_RUN: state <= PCOC_ST_RUN;
            default: state <= PCOC_ST_DELAY;
         endcase
      end
   end

   //------------------------------------------------------------
   // Ramp limiter
   //------------------------------------------------------------
   logic signed [VAL_W:0] diff;
   logic [VAL_W:0] absSpan;
   logic [VAL_W:0] stepUp;
   logic [VAL_W:0] stepDown;
   logic rampNow;

   // Step per ms is output span over ramp time
   always_comb begin
      diff = (VAL_W+1)'(target) - (VAL_W+1)'(outValue);
      absSpan = (outSpan < 0) ? (VAL_W+1)'(-outSpan) : (VAL_W+1)'(outSpan);
      stepUp = (rampUpMs == 16'h0000) ? absSpan : (absSpan / (VAL_W+1)'(rampUpMs));
      stepDown = (rampDownMs == 16'h0000) ? absSpan : (absSpan / (VAL_W+1)'(rampDownMs));
      if (stepUp == '0) stepUp = (VAL_W+1)'(1);
      if (stepDown == '0) stepDown = (VAL_W+1)'(1);
      rampNow = (rampUpMs != `PCOC_RAMP_RESET) || (rampDownMs != `PCOC_RAMP_RESET);
   end

   // Output value register
   always_ff @(posedge clock) begin
      if (reset || outputType == `PCOC_OT_NONE) begin
         outValue <= '0;
      end else if (state == PCOC_ST_RUN && !isDigital) begin
         if (!overrideActive && !enableActive && disAction == PCOC_DIS_SHUT) begin
            outValue <= loLim;
         end else if (!rampNow) begin
            outValue <= target;
         end else if (msTick) begin
            if (diff > 0) outValue <= (diff > $signed(stepUp)) ? VAL_W'(outValue + stepUp) : target;
            else if (diff < 0) outValue <= (-diff > $signed(stepDown)) ? VAL_W'(outValue - stepDown) : target;
         end
      end
   end

   //------------------------------------------------------------
   // Digital output types
   //------------------------------------------------------------
   logic latched;
   logic [15:0] blinkCount;
   logic blinkPhase;
   logic digOn;

   // Latch and blink state
   always_ff @(posedge clock) begin
      if (reset || outputType != `PCOC_OT_DIG_LAT && outputType != `PCOC_OT_DIG_ILAT) begin
         latched <= 1'b0;
      end else if (controlLevel) begin
         latched <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || blinkMs == 16'h0000) begin
         blinkCount <= 16'h0000;
         blinkPhase <= 1'b0;
      end else if (msTick) begin
         if (blinkCount + 16'h0001 >= blinkMs) begin
            blinkCount <= 16'h0000;
            blinkPhase <= !blinkPhase;
         end else begin
            blinkCount <= blinkCount + 16'h0001;
         end
      end
   end

   always_comb begin
      case (outputType)
         `PCOC_OT_DIG_NORM: digOn = controlLevel;
         `PCOC_OT_DIG_INV: digOn = !controlLevel;
         `PCOC_OT_DIG_LAT: digOn = latched;
         `PCOC_OT_DIG_ILAT: digOn = !latched;
         `PCOC_OT_BLINK: digOn = controlLevel && blinkPhase;
         default: digOn = 1'b0;
      endcase
   end

   // Digital level with override and enable precedence
   always_ff @(posedge clock) begin
      if (reset || state != PCOC_ST_RUN || !isDigital) begin
         outDigital <= 1'b0;
      end else if (overrideActive) begin
         outDigital <= (outputAtOverride != '0);
      end else if (!enableActive) begin
         outDigital <= (disAction == PCOC_DIS_KEEP) ? outDigital : 1'b0;
      end else begin
         outDigital <= digOn;
      end
   end

endmodule : pcoc_converter

// ### rtl/pcoc_params.svh
`ifndef PCOC_PARAMS_SVH
`define PCOC_PARAMS_SVH
// Clock rate and millisecond tick
`define PCOC_CLK_HZ 40000000
`define PCOC_MS_NS 1000000
`define PCOC_CLK_NS 25
`define PCOC_CYC_PER_MS (`PCOC_MS_NS / `PCOC_CLK_NS)
// Counter mode codes
`define PCOC_MODE_WINDOW 8'h46
`define PCOC_MODE_TIMED 8'h47
`define PCOC_MODE_TRIG 8'h48
// Timed mode ceiling in ms
`define PCOC_TIME_MAX_MS 16'hfde8
// Output type codes
`define PCOC_OT_NONE 4'h0
`define PCOC_OT_PWM 4'h8
`define PCOC_OT_DIG_NORM 4'h9
`define PCOC_OT_DIG_INV 4'ha
`define PCOC_OT_DIG_LAT 4'hb
`define PCOC_OT_DIG_ILAT 4'hc
`define PCOC_OT_BLINK 4'hd
// Enable and override response codes
`define PCOC_EN_ON_GROUP_MAX 3'h2
`define PCOC_EN_RESP_MAX 3'h5
`define PCOC_OVR_WHEN_ON 1'h0
// Reset values
`define PCOC_RAMP_RESET 16'h0000
`endif

// ### rtl/pcoc_pkg.sv
package pcoc_pkg;
   // Action taken when the output is disabled
   typedef enum logic [1:0] {
      PCOC_DIS_SHUT = 2'b00,
      PCOC_DIS_RAMP = 2'b01,
      PCOC_DIS_KEEP = 2'b10
   } pcoc_dis_e;
   // Output path sequencing
   typedef enum logic [1:0] {
      PCOC_ST_IDLE = 2'b00,
      PCOC_ST_DELAY = 2'b01,
      PCOC_ST_RUN = 2'b10
   } pcoc_state_e;
endpackage : pcoc_pkg

// ### bench/pcoc_checker.sv
`timescale 1ns/1ps
// ------------------------------
// Port checker
// ------------------------------
module pcoc_checker #(
   parameter int CNT_W = 18,
   parameter int VAL_W = 16
) (
   input wire logic clock, // Clock
   input wire logic reset, // Reset
   input wire logic pulseIn, // Pulse line
   input wire logic [7:0] counterMode, // Mode
   input wire logic fallingEdge, // Edge select
   input wire logic [CNT_W-1:0] countValue, // Count
   input wire logic triggerOut, // Trigger
   input wire logic [3:0] outputType, // Type
   input wire logic signed [VAL_W-1:0] controlValue, // Control
   input wire logic signed [VAL_W-1:0] controlMin, // Control min
   input wire logic signed [VAL_W-1:0] controlMax, // Control max
   input wire logic signed [VAL_W-1:0] outMin, // Out min
   input wire logic signed [VAL_W-1:0] outMax, // Out max
   input wire logic enableUsed, // Enable used
   input wire logic overrideUsed, // Override used
   input wire logic signed [VAL_W-1:0] overrideValue, // Override source
   input wire logic signed [VAL_W-1:0] overrideSrcMax, // Override max
   input wire logic overrideResponse, // Override code
   input wire logic signed [VAL_W-1:0] outputAtOverride, // Override out
   input wire logic [15:0] rampUpMs, // Ramp up
   input wire logic [15:0] rampDownMs, // Ramp down
   input wire logic signed [VAL_W-1:0] outValue, // Output
   input wire logic outDigital // Digital output
);
   logic pulsePrev;
   logic [3:0] sinceReset;
   logic edgeSeen, analogType, noRamp;
   logic signed [31:0] lo, hi, lin, target;
   // Last pulse sample
   always_ff @(posedge clock) begin
      pulsePrev <= pulseIn;
   end
   // Cycles since reset, saturating
   always_ff @(posedge clock) begin
      if (reset) sinceReset <= 4'h0;
      else if (sinceReset != 4'hf) sinceReset <= sinceReset + 4'h1;
   end
   // Expected edge, range and linear target
   assign edgeSeen = fallingEdge ? (pulsePrev & ~pulseIn) : (~pulsePrev & pulseIn);
   assign analogType = (outputType >= 4'h1) && (outputType <= 4'h8);
   assign noRamp = (rampUpMs == 16'h0000) && (rampDownMs == 16'h0000) && (sinceReset == 4'hf);
   assign lo = (outMin < outMax) ? outMin : outMax;
   assign hi = (outMin < outMax) ? outMax : outMin;
   assign lin = (controlValue - controlMin) * (outMax - outMin) / (controlMax - controlMin) + outMin;
   assign target = (lin < lo) ? lo : ((lin > hi) ? hi : lin);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence settled(c);
      c [*6];
   endsequence
   reset_clears_a: assert property (disable iff (1'b0) reset |=> countValue == '0 && !triggerOut && outValue == '0)
      else $error("outputs not cleared by reset");
   type_none_a: assert property (settled(outputType == 4'h0) |-> outValue == '0)
      else $error("unused output type drives a value");
   range_clamp_a: assert property (settled(analogType && $stable(outMin) && $stable(outMax) && noRamp)
      |-> outValue >= lo && outValue <= hi) else $error("output outside its range");
   trig_edge_a: assert property ($changed(triggerOut) |-> $past(edgeSeen) || $past(counterMode) != 8'h48)
      else $error("trigger moved without a counted edge");
   count_edge_a: assert property (counterMode == 8'h48 && $past(counterMode) == 8'h48
      && $past(counterMode, 2) == 8'h48 && $changed(countValue) |-> $past(edgeSeen, 2))
      else $error("count moved on the wrong edge");
   timed_cap_a: assert property (counterMode == 8'h47 |-> countValue <= 18'd65000)
      else $error("timed count above its ceiling");
   override_out_a: assert property (settled(analogType && overrideUsed && !overrideResponse && noRamp
      && overrideValue >= overrideSrcMax && $stable(outputAtOverride)) |-> outValue == outputAtOverride)
      else $error("override value not driven");
   control_linear_a: assert property (settled(analogType && !overrideUsed && !enableUsed && noRamp
      && $stable({outputType, controlValue, controlMin, controlMax, outMin, outMax}) && controlMin < controlMax)
      |-> outValue == target) else $error("output off its linear target");
   digital_follow_a: assert property (settled(outputType inside {4'h9, 4'ha} && !overrideUsed && !enableUsed
      && $stable({outputType, controlValue}) && (controlValue >= controlMax || controlValue <= controlMin))
      |-> outDigital == ((controlValue >= controlMax) ^ (outputType == 4'ha))) else $error("digital level wrong");
endmodule : pcoc_checker

bind pcoc_converter pcoc_checker #(.CNT_W(CNT_W), .VAL_W(VAL_W)) checker_i (.*);

// ### bench/pcoc_pulse_source.sv
`timescale 1ns/1ps
// ------------------------------
// Pulse source at the input pin
// ------------------------------
module pcoc_pulse_source (
   input wire logic clock, // Clock
   input wire logic launch, // Start a burst
   input wire logic [15:0] pulses, // Pulses per burst
   input wire logic [15:0] halfCycles, // Clocks per half pulse
   output logic pulseIn, // Pulse line
   output logic busy // Burst running
);
   int remaining = 0;
   int phase = 0;
   // Burst of whole pulses, each level held at least one clock
   initial pulseIn = 1'b0;
   always @(posedge clock) begin
      if (remaining == 0 && launch) begin
         remaining = 2 * pulses;
         phase = 0;
      end else if (remaining > 0) begin
         phase = phase + 1;
         if (phase >= halfCycles) begin
            phase = 0;
            pulseIn <= ~pulseIn;
            remaining = remaining - 1;
         end
      end
      busy <= (remaining != 0);
   end
endmodule : pcoc_pulse_source

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "pcoc_params.svh"
module tb_top;
   typedef struct {logic [3:0] ty; logic signed [15:0] cv, cmin, cmax, omin, omax; logic [31:0] exp; logic dig;} pcoc_row_s;
   logic clock = 1'b0, reset = 1'b1, launch = 1'b0, busy, pulseIn, triggerOut, outDigital;
   logic fallingEdge = 1'b0, triggerFirst = 1'b0, enableUsed = 1'b0, overrideUsed = 1'b0, overrideResponse = 1'b0;
   logic [7:0] counterMode = 8'h00;
   logic [2:0] enableResponse = 3'h0;
   logic [3:0] outputType = 4'h1;
   logic [17:0] pulsesToCount = 18'h00064, countValue;
   logic [15:0] windowMs = 16'h0001, delayMs = 16'h0000, rampUpMs = 16'h0000, rampDownMs = 16'h0000;
   logic [15:0] blinkMs = 16'h0064, pulses = 16'h0000, halfCycles = 16'h0002;
   logic signed [15:0] controlValue = 16'sh0000, controlMin = 16'sh0000, controlMax = 16'sh0064, outMin = 16'sh0000;
   logic signed [15:0] outMax = 16'sh03e8, enableValue = 16'sh0000, enableSrcMin = 16'sh0000, enableSrcMax = 16'sh000a;
   logic signed [15:0] overrideValue = 16'sh000a, overrideSrcMin = 16'sh0000, overrideSrcMax = 16'sh000a;
   logic signed [15:0] outputAtOverride = 16'sh014d, outValue;
   int mismatches = 0, checksDone = 0, cycles = 0;
   int trigPulses[4] = '{2, 1, 1, 2};
   logic [3:0] trigExp[2] = '{4'b0100, 4'b1010};
   // Control spans always rise; output spans may fall
   pcoc_row_s rows[19] = '{
      '{1, 50, 0, 100, 0, 1000, 500, 0}, '{1, 150, 0, 100, 0, 1000, 1000, 0}, '{2, 25, 0, 100, 1000, 0, 750, 0},
      '{3, 25, 0, 100, -500, 500, -250, 0}, '{4, 75, 0, 100, -1000, 1000, 500, 0}, '{5, 10, 0, 100, 0, 2000, 200, 0},
      '{6, 50, 0, 100, 400, 2000, 1200, 0}, '{7, 200, 100, 300, 0, 10000, 5000, 0}, '{8, -10, 0, 100, 0, 1000, 0, 0},
      '{0, 50, 0, 100, 0, 1000, 0, 0}, '{9, 100, 0, 100, 0, 1, 1, 1}, '{9, 0, 0, 100, 0, 1, 0, 1},
      '{10, 0, 0, 100, 0, 1, 1, 1}, '{10, 100, 0, 100, 0, 1, 0, 1}, '{11, 100, 0, 100, 0, 1, 1, 1},
      '{11, 0, 0, 100, 0, 1, 1, 1}, '{12, 100, 0, 100, 0, 1, 0, 1}, '{12, 0, 0, 100, 0, 1, 0, 1},
      '{13, 100, 0, 100, 0, 1, 0, 1}};
   pcoc_converter dut (.*);
   pcoc_pulse_source source (.*);
   // ------------------------------
   // Clock, timeout and helpers
   // ------------------------------
   initial forever #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", name, $signed(exp), $signed(got));
      end
   endtask : check_word
   task automatic check_bit(input string name, input logic exp, input logic got);
      check_word(name, {31'h0, exp}, {31'h0, got});
   endtask : check_bit
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc
   task automatic start(input int n, input int h);
      pulses = 16'(n);
      halfCycles = 16'(h);
      launch = 1'b1;
      cyc(1);
      launch = 1'b0;
   endtask : start
   task automatic burst(input int n);
      start(n, 2);
      while (busy) @(negedge clock);
      cyc(3);
   endtask : burst
   task automatic edge_pulse(input logic [31:0] expHigh, input logic [31:0] expLow);
      start(1, 10);
      while (!pulseIn) @(negedge clock);
      cyc(3);
      check_word("count high", expHigh, countValue);
      while (busy) @(negedge clock);
      cyc(3);
      check_word("count low", expLow, countValue);
   endtask : edge_pulse
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      cyc(4);
      reset = 1'b0;
      cyc(2);
      check_word("reset out", 0, outValue);
      foreach (rows[i]) begin
         outputType = rows[i].ty;
         controlValue = rows[i].cv;
         controlMin = rows[i].cmin;
         controlMax = rows[i].cmax;
         outMin = rows[i].omin;
         outMax = rows[i].omax;
         cyc(8);
         if (rows[i].dig) check_bit("digital", rows[i].exp[0], outDigital);
         else check_word("analog", rows[i].exp, outValue);
      end
      outputType = 4'h1;
      outMax = 16'sh03e8;
      for (int r = 0; r < 6; r++) begin
         enableUsed = 1'b0;
         controlValue = 16'sh0032;
         cyc(8);
         enableUsed = 1'b1;
         enableResponse = 3'(r);
         controlValue = 16'sh0050;
         cyc(8);
         check_word("enable", (r > 2) ? 800 : ((r == 2) ? 500 : 0), outValue);
      end
      enableResponse = 3'h0;
      enableValue = 16'sh000a;
      cyc(8);
      check_word("enable on", 800, outValue);
      enableValue = 16'sh0005;
      cyc(8);
      check_word("enable hold", 800, outValue);
      enableValue = 16'sh0000;
      overrideUsed = 1'b1;
      cyc(8);
      check_word("override on", 333, outValue);
      overrideResponse = 1'b1;
      cyc(8);
      check_word("override off", 0, outValue);
      enableResponse = 3'h3;
      cyc(8);
      check_word("enable pass", 800, outValue);
      overrideUsed = 1'b0;
      enableUsed = 1'b0;
      counterMode = `PCOC_MODE_TRIG;
      edge_pulse(1, 1);
      fallingEdge = 1'b1;
      edge_pulse(1, 2);
      fallingEdge = 1'b0;
      pulsesToCount = 18'h00003;
      for (int f = 0; f < 2; f++) begin
         counterMode = 8'h00;
         cyc(2);
         counterMode = `PCOC_MODE_TRIG;
         triggerFirst = (f == 0);
         foreach (trigPulses[i]) begin
            burst(trigPulses[i]);
            check_bit("trigger", trigExp[f][i], triggerOut);
         end
      end
      reset = 1'b1;
      cyc(4);
      reset = 1'b0;
      cyc(2);
      check_bit("trigger reset", 1'b0, triggerOut);
      counterMode = `PCOC_MODE_TIMED;
      burst(4);
      check_bit("timed short", 1'b1, countValue <= 18'h00001);
      counterMode = `PCOC_MODE_WINDOW;
      controlValue = 16'sh0000;
      cyc(8);
      rampUpMs = 16'h0002;
      rampDownMs = 16'h0002;
      controlValue = 16'sh0064;
      start(210, 200);
      cyc(2);
      check_bit("ramp step", 1'b1, outValue < 16'sh03e8);
      while (countValue == '0) @(negedge clock);
      check_word("ramp half", 500, outValue);
      cyc(40005);
      check_word("window", 100, countValue);
      check_word("ramp end", 1000, outValue);
      summarize();
   end
endmodule : tb_top
